// file: hw/itcf_timer.sv
// interval timer, carry flag, chip-enable reset sync and timer interrupt
`timescale 1ns/1ps
`default_nettype none
`include "itcf_defines.svh"

module itcf_timer #(
  parameter int unsigned HALF5   = `ITCF_HALF5_CYC,
  parameter int unsigned HALF100 = `ITCF_HALF100_CYC
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  // register window
  input  wire logic [5:0] regAddr,
  input  wire logic       regRd,
  input  wire logic       regWr,
  input  wire logic [3:0] regWrData,
  output logic      [3:0] rdData_ff,
  // pins
  input  wire logic       mainsIn,
  input  wire logic       chipEnable,
  // status and events
  output logic            carryFlag_ff,
  output logic            timerIrq_ff,
  output logic            ceReset_ff
);

  localparam int W5   = $clog2(HALF5);
  localparam int W100 = $clog2(HALF100);

  logic [W5-1:0]   c5_ff, nxt_c5;
  logic [W100-1:0] c100_ff, nxt_c100;
  logic            p200_ff, nxt_p200;
  logic            p10_ff, nxt_p10;
  logic [2:0]      extCnt_ff, nxt_extCnt;
  logic            mainsPrev_ff, nxt_mainsPrev;
  logic [3:0]      mode_ff, nxt_mode;
  logic [3:0]      permit_ff, nxt_permit;
  logic [3:0]      request_ff, nxt_request;
  logic            armed_ff, nxt_armed;
  logic            prevA_ff, nxt_prevA;
  logic            prevB_ff, nxt_prevB;
  logic            cePrev_ff, nxt_cePrev;
  logic            cePend_ff, nxt_cePend;
  logic            swDone_ff, nxt_swDone;
  logic            nxt_carry, nxt_irq, nxt_ceReset;
  logic [3:0]      nxt_rdData;

  itcf_pkg::itcf_sel_t sel;
  logic extLvl, selA, selB, modeChg, setEvt, rdJudge, wrJudge;

  always_comb begin
    sel     = itcf_pkg::itcf_sel_t'(mode_ff[2:0]);
    // mains divided by 5 or 6 gives the 10 Hz external base
    extLvl  = (extCnt_ff < 3'h2);
    // codes above 3 fall back to the 10 Hz base
    unique case (sel)
      itcf_pkg::SEL_200HZ: selA = p200_ff;
      itcf_pkg::SEL_EXT:   selA = extLvl;
      itcf_pkg::SEL_MAINS: selA = mainsIn;
      default:             selA = p10_ff;
    endcase
    // selector B follows the internal/external choice only
    selB    = (mode_ff[1]) ? extLvl : p10_ff;
    modeChg = regWr && (regAddr == `ITCF_ADDR_MODE) && (regWrData[2:0] != mode_ff[2:0]);
    rdJudge = regRd && (regAddr == `ITCF_ADDR_JUDGE);
    wrJudge = regWr && (regAddr == `ITCF_ADDR_JUDGE);
    // a switch is judged one cycle on, by the newly selected pulse alone
    setEvt  = armed_ff && selA && (!prevA_ff || swDone_ff);
  end

  // free-running time bases, never reloaded by selection changes
  always_comb begin
    nxt_c5        = c5_ff;
    nxt_p200      = p200_ff;
    nxt_c100      = c100_ff;
    nxt_p10       = p10_ff;
    nxt_extCnt    = extCnt_ff;
    nxt_mainsPrev = mainsIn;
    if (c5_ff == W5'(HALF5 - 1)) begin
      nxt_c5   = '0;
      nxt_p200 = !p200_ff;
    end else begin
      nxt_c5 = c5_ff + W5'(1);
    end
    if (c100_ff == W100'(HALF100 - 1)) begin
      nxt_c100 = '0;
      nxt_p10  = !p10_ff;
    end else begin
      nxt_c100 = c100_ff + W100'(1);
    end
    if (mainsIn && !mainsPrev_ff) begin
      if (extCnt_ff >= (mode_ff[`ITCF_MODE_DIV6_BIT] ? 3'h5 : 3'h4)) begin
        nxt_extCnt = 3'h0;
      end else begin
        nxt_extCnt = extCnt_ff + 3'h1;
      end
    end
  end

  // mode register holds the selection; the switch itself is handled in setEvt
  always_comb begin
    nxt_mode   = mode_ff;
    nxt_permit = permit_ff;
    // kept one cycle so the old pulse level cannot decide the switch
    nxt_swDone = modeChg;
    if (regWr && regAddr == `ITCF_ADDR_MODE) begin
      nxt_mode = regWrData;
    end
    if (regWr && regAddr == `ITCF_ADDR_PERMIT) begin
      nxt_permit = regWrData;
    end
  end

  // carry flip-flop and its judge-register mirror are one bit
  always_comb begin
    nxt_armed  = armed_ff;
    nxt_carry  = carryFlag_ff;
    nxt_prevA  = selA;
    nxt_rdData = 4'h0;
    if (rdJudge) begin
      nxt_armed  = 1'b1;
      nxt_carry  = 1'b0;
      nxt_rdData = {3'h0, carryFlag_ff};
    end
    // set wins over a coinciding read so no interval is lost
    if (setEvt) begin
      nxt_carry = 1'b1;
    end
    if (regRd) begin
      unique case (regAddr)
        `ITCF_ADDR_MODE:    nxt_rdData = mode_ff;
        `ITCF_ADDR_JUDGE:   nxt_rdData = {3'h0, carryFlag_ff};
        `ITCF_ADDR_PERMIT:  nxt_rdData = permit_ff;
        `ITCF_ADDR_REQUEST: nxt_rdData = request_ff;
        default:            nxt_rdData = 4'h0;
      endcase
    end
    // a write to the judge register is dropped on purpose
    if (wrJudge) begin
      nxt_carry = nxt_carry;
    end
  end

  // chip-enable reset waits for the next carry set; a read at that moment defers it
  // cePrev_ff resets low, so a pin already high at release counts as a rise
  always_comb begin
    nxt_cePrev  = chipEnable;
    nxt_cePend  = cePend_ff;
    nxt_ceReset = 1'b0;
    if (chipEnable && !cePrev_ff) begin
      nxt_cePend = 1'b1;
    end
    if (cePend_ff && setEvt && !rdJudge) begin
      nxt_ceReset = 1'b1;
      nxt_cePend  = 1'b0;
    end
  end

  // timer interrupt request, set by selector B edge; set beats software clear
  always_comb begin
    nxt_prevB   = selB;
    nxt_request = request_ff;
    if (regWr && regAddr == `ITCF_ADDR_REQUEST) begin
      nxt_request = regWrData;
    end
    if (selB && !prevB_ff) begin
      nxt_request[`ITCF_TIMER_BIT] = 1'b1;
    end
    nxt_irq = nxt_request[`ITCF_TIMER_BIT] && nxt_permit[`ITCF_TIMER_BIT];
  end

  // reset leaves a disarmed carry and the 10 Hz internal base
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      swDone_ff    <= 1'b0;
      c5_ff        <= '0;
      c100_ff      <= '0;
      p200_ff      <= 1'b0;
      p10_ff       <= 1'b0;
      extCnt_ff    <= 3'h0;
      mainsPrev_ff <= 1'b0;
      mode_ff      <= `ITCF_MODE_RESET;
      permit_ff    <= 4'h0;
      request_ff   <= 4'h0;
      armed_ff     <= 1'b0;
      carryFlag_ff <= 1'b0;
      prevA_ff     <= 1'b0;
      prevB_ff     <= 1'b0;
      cePrev_ff    <= 1'b0;
      cePend_ff    <= 1'b0;
      ceReset_ff   <= 1'b0;
      timerIrq_ff  <= 1'b0;
      rdData_ff    <= 4'h0;
    end else if (clkEn) begin
      swDone_ff    <= nxt_swDone;
      c5_ff        <= nxt_c5;
      c100_ff      <= nxt_c100;
      p200_ff      <= nxt_p200;
      p10_ff       <= nxt_p10;
      extCnt_ff    <= nxt_extCnt;
      mainsPrev_ff <= nxt_mainsPrev;
      mode_ff      <= nxt_mode;
      permit_ff    <= nxt_permit;
      request_ff   <= nxt_request;
      armed_ff     <= nxt_armed;
      carryFlag_ff <= nxt_carry;
      prevA_ff     <= nxt_prevA;
      prevB_ff     <= nxt_prevB;
      cePrev_ff    <= nxt_cePrev;
      cePend_ff    <= nxt_cePend;
      ceReset_ff   <= nxt_ceReset;
      timerIrq_ff  <= nxt_irq;
      rdData_ff    <= nxt_rdData;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence rdSetCoincide;
    clkEn && cePend_ff && setEvt && rdJudge;
  endsequence

  sequence ceFire;
    clkEn && cePend_ff && setEvt && !rdJudge;
  endsequence

  carry_set_a: assert property (clkEn && setEvt |=> carryFlag_ff)
    else $error("carry did not set on pulse edge");
  read_clear_a: assert property (clkEn && rdJudge && !setEvt |=> !carryFlag_ff)
    else $error("carry read did not clear");
  first_read_a: assert property (clkEn && rdJudge && !armed_ff |=> rdData_ff == 4'h0)
    else $error("first carry read not zero");
  unarmed_hold_a: assert property (!armed_ff |-> !carryFlag_ff)
    else $error("carry set before first read");
  ce_reset_a: assert property (ceFire |=> ceReset_ff ##1 !ceReset_ff || clkEn == 1'b0)
    else $error("chip-enable reset missing or stretched");
  ce_defer_a: assert property (rdSetCoincide |=> !ceReset_ff && cePend_ff)
    else $error("chip-enable reset not deferred");
  judge_ro_a: assert property (clkEn && wrJudge && !setEvt && !rdJudge
                               |=> carryFlag_ff == $past(carryFlag_ff))
    else $error("write altered carry flag");
  irq_req_a: assert property (clkEn && selB && !prevB_ff |=> request_ff[0])
    else $error("timer request not raised");
  irq_out_a: assert property (clkEn |=> timerIrq_ff == (request_ff[0] && permit_ff[0]))
    else $error("interrupt output mismatch");
  mirror_a: assert property (clkEn && regRd && regAddr == `ITCF_ADDR_JUDGE
                             |=> rdData_ff[0] == $past(carryFlag_ff))
    else $error("judge bit does not mirror carry");

  // a switch lands in the cycle after the mode write, seen through swDone_ff
  sequence switchToHigh;
    clkEn && swDone_ff && armed_ff && selA;
  endsequence

  sequence switchToLow;
    clkEn && swDone_ff && !selA && !rdJudge;
  endsequence

  sequence fastWrap;
    clkEn && (c5_ff == W5'(HALF5 - 1));
  endsequence

  sequence slowWrap;
    clkEn && (c100_ff == W100'(HALF100 - 1));
  endsequence

  switch_set_a: assert property (switchToHigh |=> carryFlag_ff)
    else $error("switch to high pulse did not set carry");
  switch_hold_a: assert property (switchToLow
                                  |=> carryFlag_ff == $past(carryFlag_ff))
    else $error("switch to low pulse changed carry");

  // bases wrap and toggle on their own, whatever the selection does
  fast_wrap_a: assert property (fastWrap |=> c5_ff == '0 && p200_ff != $past(p200_ff))
    else $error("fast base did not wrap");
  slow_wrap_a: assert property (slowWrap |=> c100_ff == '0 && p10_ff != $past(p10_ff))
    else $error("slow base did not wrap");
  fast_step_a: assert property (clkEn && !(c5_ff == W5'(HALF5 - 1))
                                |=> c5_ff == $past(c5_ff) + W5'(1))
    else $error("fast base skipped a count");

  // mains divider stays inside its cycle for either ratio
  div_range_a: assert property (extCnt_ff <= 3'h5)
    else $error("mains divider out of range");
  div5_wrap_a: assert property (clkEn && mainsIn && !mainsPrev_ff
                                && !mode_ff[`ITCF_MODE_DIV6_BIT] && extCnt_ff == 3'h4
                                |=> extCnt_ff == 3'h0)
    else $error("divide by 5 did not wrap");
  div6_step_a: assert property (clkEn && mainsIn && !mainsPrev_ff
                                && mode_ff[`ITCF_MODE_DIV6_BIT] && extCnt_ff == 3'h4
                                |=> extCnt_ff == 3'h5)
    else $error("divide by 6 wrapped early");

  ce_pend_a: assert property (clkEn && chipEnable && !cePrev_ff && !cePend_ff
                              |=> cePend_ff)
    else $error("chip-enable rise not remembered");
  rd_idle_a: assert property (clkEn && !regRd |=> rdData_ff == 4'h0)
    else $error("read data not idle");
  // clock enable low must hold the carry flag, the mode register and the fast counter c5_ff
  freeze_a: assert property (!clkEn |=> $stable(carryFlag_ff) && $stable(mode_ff)
                             && $stable(c5_ff))
    else $error("state moved with clock enable low");

endmodule
`default_nettype wire

// file: hw/itcf_defines.svh
// constants for the interval timer with carry flag
`ifndef ITCF_DEFINES_SVH
`define ITCF_DEFINES_SVH

`define ITCF_ADDR_MODE     6'h0_9
`define ITCF_ADDR_JUDGE    6'h1_7
`define ITCF_ADDR_PERMIT   6'h2_F
`define ITCF_ADDR_REQUEST  6'h3_F

`define ITCF_MODE_RESET    4'h0
`define ITCF_MODE_DIV6_BIT 3
`define ITCF_TIMER_BIT     0
`define ITCF_CARRY_BIT     0

`define ITCF_CLK_NS        25
`define ITCF_T5MS_NS       5000000
`define ITCF_T100MS_NS     100000000
`define ITCF_HALF5_CYC     (`ITCF_T5MS_NS / `ITCF_CLK_NS / 2)
`define ITCF_HALF100_CYC   (`ITCF_T100MS_NS / `ITCF_CLK_NS / 2)

`endif

// file: hw/itcf_pkg.sv
// types for the interval timer with carry flag
package itcf_pkg;
  typedef enum logic [2:0] {
    SEL_10HZ  = 3'b000,
    SEL_200HZ = 3'b001,
    SEL_EXT   = 3'b010,
    SEL_MAINS = 3'b011
  } itcf_sel_t;
endpackage

// file: dv/interval_timer_carry_flag_tb_top.sv
// self-checking bench for the interval timer with carry flag
`timescale 1ns/1ps
`default_nettype none
`include "itcf_defines.svh"

module interval_timer_carry_flag_tb_top;
  // short half periods keep every interval between 4 and 40 clocks
  localparam int H5   = 4;
  localparam int H100 = 20;
  typedef struct packed {
    logic [5:0] a;
    logic [3:0] d;
    logic [3:0] e;
  } itcf_row_t;
  logic       clock      = 1'b0;
  logic       sys_rst    = 1'b1;
  logic       clkEn      = 1'b1;
  logic [5:0] regAddr    = 6'h0_0;
  logic       regRd      = 1'b0;
  logic       regWr      = 1'b0;
  logic [3:0] regWrData  = 4'h0;
  logic       mainsIn    = 1'b0;
  logic       chipEnable = 1'b0;
  logic [3:0] rdData_ff;
  logic       carryFlag_ff;
  logic       timerIrq_ff;
  logic       ceReset_ff;
  int         err_total   = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  int         ceCount     = 0;
  int         t0;
  int         t1;
  logic [3:0] rv;
  itcf_row_t  rows [5] = '{'{6'h0_9, 4'h8, 4'h8}, '{6'h0_9, 4'h0, 4'h0},
                           '{6'h2_F, 4'h1, 4'h1}, '{6'h2_F, 4'h0, 4'h0},
                           '{6'h0_5, 4'h7, 4'h0}};
  // mains toggles every 2 clocks: raw gives 4 clocks, /5 gives 20 and /6 gives 24
  logic [3:0] ivMode [5] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'h3};
  int         ivSpan [5] = '{2 * H100, 2 * H5, 20, 24, 4};

  itcf_timer #(.HALF5(H5), .HALF100(H100)) dut (
    .clock(clock), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regRd(regRd), .regWr(regWr), .regWrData(regWrData), .rdData_ff(rdData_ff),
    .mainsIn(mainsIn), .chipEnable(chipEnable), .carryFlag_ff(carryFlag_ff),
    .timerIrq_ff(timerIrq_ff), .ceReset_ff(ceReset_ff));

  always #12.5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;
  always @(negedge clock) begin
    mainsIn <= cyc[1];
    if (ceReset_ff === 1'b1) begin
      ceCount <= ceCount + 1;
    end
  end

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(logic [5:0] a, logic [3:0] d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWr = 1'b1;
    @(negedge clock);
    regWr = 1'b0;
  endtask

  task automatic rd(logic [5:0] a, output logic [3:0] d);
    @(negedge clock);
    regAddr = a;
    regRd = 1'b1;
    @(negedge clock);
    regRd = 1'b0;
    d = rdData_ff;
  endtask

  // reads until the flag is seen low, so the next set is a fresh one
  task automatic clearFlag();
    logic [3:0] junk;
    rd(`ITCF_ADDR_JUDGE, junk);
    for (int k = 0; k < 4 && carryFlag_ff !== 1'b0; k++) begin
      rd(`ITCF_ADDR_JUDGE, junk);
    end
  endtask

  task automatic waitFlag(int lim, output int at);
    at = -1;
    for (int i = 0; i < lim && at < 0; i++) begin
      @(negedge clock);
      if (carryFlag_ff === 1'b1) at = cyc;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 20000);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    check("outputs after reset", 7'h0_0, {rdData_ff, carryFlag_ff, timerIrq_ff, ceReset_ff});
    repeat (50) @(negedge clock);
    check("carry before first read", 1'b0, carryFlag_ff);
    rd(`ITCF_ADDR_JUDGE, rv);
    check("first judge read", 4'h0, rv);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rv);
      check("register readback", rows[i].e, rv);
    end
    // set-to-set spacing per mode, sources keep running across switches
    foreach (ivMode[i]) begin
      wr(`ITCF_ADDR_MODE, ivMode[i]);
      clearFlag();
      waitFlag(3 * ivSpan[i], t0);
      rd(`ITCF_ADDR_JUDGE, rv);
      waitFlag(3 * ivSpan[i], t1);
      rd(`ITCF_ADDR_JUDGE, rv);
      check("set interval", ivSpan[i], t1 - t0);
      check("judge after set", 4'h1, rv);
    end
    wr(`ITCF_ADDR_MODE, 4'h0);
    waitFlag(3 * H100, t0);
    rd(`ITCF_ADDR_JUDGE, rv);
    wr(`ITCF_ADDR_JUDGE, 4'hF);
    check("carry after judge write", 1'b0, carryFlag_ff);
    rd(`ITCF_ADDR_JUDGE, rv);
    check("judge after write", 4'h0, rv);
    wr(`ITCF_ADDR_PERMIT, 4'h0);
    wr(`ITCF_ADDR_REQUEST, 4'h0);
    check("irq while masked", 1'b0, timerIrq_ff);
    wr(`ITCF_ADDR_PERMIT, 4'h1);
    for (int i = 0; i < 3 * H100 && timerIrq_ff !== 1'b1; i++) @(negedge clock);
    check("periodic irq", 1'b1, timerIrq_ff);
    wr(`ITCF_ADDR_REQUEST, 4'h0);
    repeat (2) @(negedge clock);
    check("irq after clear", 1'b0, timerIrq_ff);
    check("ce resets without rise", 0, ceCount);
    chipEnable = 1'b1;
    for (int i = 0; i < 3 * H100 && ceReset_ff !== 1'b1; i++) @(negedge clock);
    check("carry at ce reset", 2'b11, {ceReset_ff, carryFlag_ff});
    repeat (5 * H100) @(negedge clock);
    check("ce reset count", 1, ceCount);
    // read meets a set while a chip-enable reset waits: read wins, reset waits
    chipEnable = 1'b0;
    wr(`ITCF_ADDR_MODE, 4'h1);
    clearFlag();
    waitFlag(4 * H5, t0);
    chipEnable = 1'b1;
    repeat (2 * H5 - 2) @(negedge clock);
    rd(`ITCF_ADDR_JUDGE, rv);
    check("read beside set", 4'h1, rv);
    check("ce reset deferred", 1, ceCount);
    repeat (4 * H5) @(negedge clock);
    check("ce reset after deferral", 2, ceCount);
    // second reset mid-run must disarm the carry again
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    check("outputs after second reset", 7'h0_0, {rdData_ff, carryFlag_ff, timerIrq_ff, ceReset_ff});
    repeat (3 * H100) @(negedge clock);
    check("carry after second reset", 1'b0, carryFlag_ff);
    rd(`ITCF_ADDR_JUDGE, rv);
    check("first read after second reset", 4'h0, rv);
    wrap_up();
  end
endmodule
`default_nettype wire
